// file: design/ebi_cpu_end.sv
// Processor end: bus master, clock ratios and interrupt pin sampling
// Behaviour
// - All bus activity on bus clock rising edges
// - Idle: data floated, strobes and enables high
// - Processor clock is master divided 1,2,4,8
// - Bus clock halved when halving select low
// - Master clock divided by 2 shown on free-running output
// - Uncached or cache-disabled accesses use single reads
// - Single read: begin pulse, read strobe, final-transfer
// - Controller acks; data captured one clock later
// - Single read: final released on ack, strobe held
// - Bus fault ends a read with error
// - Cache misses burst unless dcache multiword refill off
// - Burst code 00..11 means 4..32 words
// - Burst start: begin pulse, read and multiword strobes
// - Each capture advances address; next ack overlaps
// - Final asserted at next-to-last ack, released at last
// - Strobes released on last capture, address advanced once more
// - Fault ends burst; only captured words delivered
// - Writes single: store strobe, data from clock two
// - Write ends clock after ack, final released on ack
// - Bus fault ignored during writes
// - Falling edge on nmi input latched as exception
// - Nmi exception waits for idle bus and ownership
// - Maskable inputs sampled as levels into pending field
`timescale 1ns/10ps
module ebi_cpu_end (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  // Clock configuration
  input  wire logic [1:0]                 clock_divide_select_i,
  input  wire logic                       bus_halving_select_i,
  output logic                            free_running_clock_o,
  // Access request
  input  wire logic                       req_valid_i,
  output logic                            req_ready_o,
  input  wire logic                       req_write_i,
  input  wire logic                       req_cached_i,
  input  wire logic                       req_instr_i,
  input  wire logic [ebi_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [ebi_pkg::BE_W-1:0]   req_byte_en_n_i,
  input  wire logic [ebi_pkg::DATA_W-1:0] req_wdata_i,
  // Cache configuration
  input  wire logic                       icache_enable_i,
  input  wire logic                       dcache_enable_i,
  input  wire logic                       dcache_multiword_refill_i,
  input  wire logic [1:0]                 icache_refill_length_i,
  input  wire logic [1:0]                 dcache_refill_length_i,
  // Access results
  output logic                            rd_valid_o,
  output logic [ebi_pkg::DATA_W-1:0]      rd_data_o,
  output logic                            rd_last_o,
  output logic                            bus_error_o,
  output logic                            write_done_o,
  // Interrupt pins and exceptions
  input  wire logic                       nmi_n_i,
  input  wire logic [ebi_pkg::NIRQ-1:0]   int_n_i,
  input  wire logic [ebi_pkg::NIRQ-1:0]   irq_mask_field_i,
  input  wire logic                       other_master_owns_i,
  output logic                            nmi_exception_o,
  output logic [ebi_pkg::NIRQ-1:0]        pending_irq_field_o,
  output logic                            irq_exception_o,
  // Bus
  ebi_bus_if.dev                          bus
);
  import ebi_pkg::*;

  ebi_state_e        st_r, st_nxt;
  logic              begin_n_r, begin_n_nxt;
  logic              rd_n_r, rd_n_nxt;
  logic              wr_n_r, wr_n_nxt;
  logic              last_n_r, last_n_nxt;
  logic              burst_n_r, burst_n_nxt;
  logic [1:0]        code_r, code_nxt;
  logic [BE_W-1:0]   be_n_r, be_n_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              doe_r, doe_nxt;
  logic [CNT_W-1:0]  words_r, words_nxt;
  logic [CNT_W-1:0]  acks_r, acks_nxt;
  logic [CNT_W-1:0]  caps_r, caps_nxt;
  logic              pend_r, pend_nxt;
  logic              cap_now, cap_last, err_now, wdone_now;
  logic [DIV_W-1:0]  div_cnt_r;
  logic              tick_r, ready_r, free_running_clock_r;
  logic              rd_valid_r, rd_last_r, err_r, wdone_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [1:0]        nmi_sync_r;
  logic              nmi_prev_r, nmi_pend_r, nmi_exc_r;
  logic [NIRQ-1:0]   int_s1_r, int_s2_r, pend_irq_r;
  logic              irq_exc_r;

  // Ratio is 2^(select + inverted halving select); the slowest is master/16
  wire [2:0]       shift = {1'b0, clock_divide_select_i} +
                           {2'b00, ~bus_halving_select_i};
  wire [DIV_W-1:0] ratio_m1 = DIV_W'((DIV_ONE << shift) - DIV_ONE);
  wire             tick_nxt = div_cnt_r >= ratio_m1;

  wire ack_seen   = ~bus.target_done_n;
  wire fault_seen = ~bus.bus_fault_in_n;
  wire take       = ready_r & req_valid_i;
  wire burst_req  = ~req_write_i & req_cached_i &
                    (req_instr_i ? icache_enable_i :
                     dcache_enable_i & dcache_multiword_refill_i);
  wire [1:0] len_code = req_instr_i ? icache_refill_length_i :
                                      dcache_refill_length_i;
  wire idle_after = tick_r ? (st_nxt == ST_IDLE) : (st_r == ST_IDLE);

  always_comb begin
    st_nxt = st_r;        begin_n_nxt = 1'b1;   rd_n_nxt = rd_n_r;
    wr_n_nxt = wr_n_r;    last_n_nxt = last_n_r; burst_n_nxt = burst_n_r;
    code_nxt = code_r;    be_n_nxt = be_n_r;    addr_nxt = addr_r;
    dout_nxt = dout_r;    doe_nxt = doe_r;      words_nxt = words_r;
    acks_nxt = acks_r;    caps_nxt = caps_r;    pend_nxt = 1'b0;
    cap_now = 1'b0;       cap_last = 1'b0;      err_now = 1'b0;
    wdone_now = 1'b0;
    case (st_r)
      ST_IDLE: if (take) begin
        begin_n_nxt = 1'b0;
        be_n_nxt = req_byte_en_n_i;
        addr_nxt = req_addr_i;
        acks_nxt = '0;
        caps_nxt = '0;
        if (req_write_i) begin
          st_nxt = ST_WRITE;
          wr_n_nxt = 1'b0;
          last_n_nxt = 1'b0;
          dout_nxt = req_wdata_i;
        end else if (burst_req) begin
          st_nxt = ST_BURST;
          rd_n_nxt = 1'b0;
          burst_n_nxt = 1'b0;
          code_nxt = len_code;
          words_nxt = CNT_W'(BURST_BASE_WORDS << len_code);
        end else begin
          st_nxt = ST_SREAD;
          rd_n_nxt = 1'b0;
          last_n_nxt = 1'b0;
        end
      end
      ST_SREAD: begin
        if (fault_seen) err_now = 1'b1;
        else if (ack_seen) begin
          last_n_nxt = 1'b1;
          st_nxt = ST_SCAP;
        end
      end
      ST_SCAP: begin
        if (fault_seen) err_now = 1'b1;
        else begin
          cap_now = 1'b1;
          cap_last = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      ST_BURST: begin
        if (fault_seen) err_now = 1'b1;
        else begin
          if (pend_r) begin
            cap_now = 1'b1;
            caps_nxt = caps_r + ONE_WORD;
            addr_nxt = addr_r + ADDR_STEP;
            if (caps_nxt == words_r) begin
              cap_last = 1'b1;
              st_nxt = ST_IDLE;
            end
          end
          if (ack_seen && acks_r != words_r) begin
            acks_nxt = acks_r + ONE_WORD;
            pend_nxt = 1'b1;
            if (acks_nxt == words_r - ONE_WORD) last_n_nxt = 1'b0;
            if (acks_nxt == words_r) last_n_nxt = 1'b1;
          end
        end
      end
      ST_WRITE: begin
        doe_nxt = 1'b1;
        if (ack_seen) begin
          last_n_nxt = 1'b1;
          st_nxt = ST_WEND;
        end
      end
      ST_WEND: begin
        wdone_now = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Ending a cycle returns strobes, enables and the data driver to idle; address and burst code hold
    if (err_now || (st_r != ST_IDLE && st_nxt == ST_IDLE)) begin
      st_nxt = ST_IDLE;
      rd_n_nxt = 1'b1;
      wr_n_nxt = 1'b1;
      last_n_nxt = 1'b1;
      burst_n_nxt = 1'b1;
      be_n_nxt = BE_IDLE_N;
      doe_nxt = 1'b0;
      pend_nxt = 1'b0;
    end
  end

  // Divider and bus edge; the state registers below move only on that edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
      ready_r   <= 1'b0;
      free_running_clock_r    <= 1'b0;
    end else begin
      div_cnt_r <= tick_nxt ? '0 : div_cnt_r + 1'b1;
      tick_r    <= tick_nxt;
      ready_r   <= tick_nxt & idle_after;
      free_running_clock_r    <= ~free_running_clock_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= ST_IDLE;    begin_n_r <= 1'b1;  rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;     last_n_r <= 1'b1;   burst_n_r <= 1'b1;
      be_n_r <= BE_IDLE_N; doe_r <= 1'b0;     pend_r <= 1'b0;
      code_r <= '0;       addr_r <= '0;       dout_r <= '0;
      words_r <= ONE_WORD; acks_r <= '0;      caps_r <= '0;
    end else if (tick_r) begin
      st_r <= st_nxt;     begin_n_r <= begin_n_nxt; rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt; last_n_r <= last_n_nxt; burst_n_r <= burst_n_nxt;
      be_n_r <= be_n_nxt; doe_r <= doe_nxt;   pend_r <= pend_nxt;
      code_r <= code_nxt; addr_r <= addr_nxt; dout_r <= dout_nxt;
      words_r <= words_nxt; acks_r <= acks_nxt; caps_r <= caps_nxt;
    end
  end

  // Result pulses last one master clock
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_valid_r <= 1'b0;
      rd_last_r  <= 1'b0;
      err_r      <= 1'b0;
      wdone_r    <= 1'b0;
      rd_data_r  <= '0;
    end else begin
      rd_valid_r <= tick_r & cap_now;
      rd_last_r  <= tick_r & cap_last;
      err_r      <= tick_r & err_now;
      wdone_r    <= tick_r & wdone_now;
      if (tick_r & cap_now) rd_data_r <= bus.data;
    end
  end

  // Interrupt pins are asynchronous: two flops before any use
  wire nmi_edge  = tick_r & nmi_prev_r & ~nmi_sync_r[1];
  wire nmi_issue = nmi_pend_r & tick_r & (st_r == ST_IDLE) &
                   ~other_master_owns_i;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      nmi_sync_r <= 2'h3;
      nmi_prev_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      nmi_exc_r  <= 1'b0;
      int_s1_r   <= '1;
      int_s2_r   <= '1;
      pend_irq_r <= '0;
      irq_exc_r  <= 1'b0;
    end else begin
      nmi_sync_r <= {nmi_sync_r[0], nmi_n_i};
      int_s1_r   <= int_n_i;
      int_s2_r   <= int_s1_r;
      if (tick_r) nmi_prev_r <= nmi_sync_r[1];
      // A new edge in the issuing cycle stays latched
      nmi_pend_r <= nmi_edge | (nmi_pend_r & ~nmi_issue);
      nmi_exc_r  <= nmi_issue;
      if (tick_r) pend_irq_r <= ~int_s2_r;
      irq_exc_r  <= |(pend_irq_r & irq_mask_field_i);
    end
  end

  assign bus.bus_tick           = tick_r;
  assign bus.bus_cycle_begin_n  = begin_n_r;
  assign bus.read_strobe_n      = rd_n_r;
  assign bus.store_strobe_n     = wr_n_r;
  assign bus.final_transfer_n   = last_n_r;
  assign bus.multiword_read_n   = burst_n_r;
  assign bus.burst_length_code  = code_r;
  assign bus.byte_lane_enable_n = be_n_r;
  assign bus.word_addr          = addr_r;
  assign bus.dev_data           = dout_r;
  assign bus.dev_data_oe        = doe_r;
  assign free_running_clock_o   = free_running_clock_r;
  assign req_ready_o            = ready_r;
  assign rd_valid_o             = rd_valid_r;
  assign rd_data_o              = rd_data_r;
  assign rd_last_o              = rd_last_r;
  assign bus_error_o            = err_r;
  assign write_done_o           = wdone_r;
  assign nmi_exception_o        = nmi_exc_r;
  assign pending_irq_field_o    = pend_irq_r;
  assign irq_exception_o        = irq_exc_r;
endmodule : ebi_cpu_end

// file: design/ebi_pkg.sv
// Shared constants and types for both ends of the external bus interface
package ebi_pkg;
  localparam int ADDR_W        = 30;   // Word address, byte bits dropped
  localparam int DATA_W        = 32;
  localparam int BE_W          = 4;
  localparam int NIRQ          = 6;
  localparam int CNT_W         = 6;    // Holds word counts up to 32
  localparam int DIV_W         = 4;    // Bus clock divider, up to /16
  localparam int WAIT_W        = 4;
  localparam int FIFO_DEPTH    = 8;
  localparam int CLK_PERIOD_NS = 20;
  // Burst length code n selects BURST_BASE_WORDS << n words
  localparam logic [CNT_W-1:0]  BURST_BASE_WORDS = 6'h04;
  localparam logic [CNT_W-1:0]  ONE_WORD         = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_STEP        = 30'h00000001;
  localparam logic [BE_W-1:0]   BE_IDLE_N        = 4'hF;
  localparam logic [DIV_W:0]    DIV_ONE          = 5'h01;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SREAD, ST_SCAP, ST_BURST, ST_WRITE, ST_WEND
  } ebi_state_e;
endpackage : ebi_pkg

// file: design/ebi_bus_if.sv
// Bus pins joining the processor end and the memory controller end
`timescale 1ns/10ps
interface ebi_bus_if;
  import ebi_pkg::*;
  logic                bus_tick;
  logic                bus_cycle_begin_n;
  logic                read_strobe_n;
  logic                store_strobe_n;
  logic                final_transfer_n;
  logic                multiword_read_n;
  logic [1:0]          burst_length_code;
  logic [BE_W-1:0]     byte_lane_enable_n;
  logic [ADDR_W-1:0]   word_addr;
  logic [DATA_W-1:0]   dev_data;
  logic                dev_data_oe;
  logic [DATA_W-1:0]   ctl_data;
  logic                ctl_data_oe;
  logic [DATA_W-1:0]   data;
  logic                target_done_n;
  logic                bus_fault_in_n;

  // Floating bus reads as zero here
  assign data = dev_data_oe ? dev_data : (ctl_data_oe ? ctl_data : '0);

  modport dev (
    output bus_tick, bus_cycle_begin_n, read_strobe_n, store_strobe_n,
           final_transfer_n, multiword_read_n, burst_length_code,
           byte_lane_enable_n, word_addr, dev_data, dev_data_oe,
    input  data, target_done_n, bus_fault_in_n
  );
  modport ctl (
    input  bus_tick, bus_cycle_begin_n, read_strobe_n, store_strobe_n,
           final_transfer_n, multiword_read_n, burst_length_code,
           byte_lane_enable_n, word_addr, data,
    output ctl_data, ctl_data_oe, target_done_n, bus_fault_in_n
  );
endinterface : ebi_bus_if

// file: design/ebi_fifo.sv
// Parameterised FIFO with valid/ready on both sides and registered flags
`timescale 1ns/10ps
module ebi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("ebi_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic [PW:0]      count_nxt;
  logic             full_r;
  logic             nonempty_r;
  wire              push = in_valid_i & ~full_r;
  wire              pop  = out_ready_i & nonempty_r;

  always_comb begin
    count_nxt = count_r;
    if (push & ~pop) count_nxt = count_r + 1'b1;
    if (pop & ~push) count_nxt = count_r - 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      full_r     <= 1'b0;
      nonempty_r <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r    <= count_nxt;
      full_r     <= count_nxt == (PW+1)'(DEPTH);
      nonempty_r <= count_nxt != '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr_r] <= in_data_i;
  end

  assign in_ready_o  = ~full_r;
  assign out_valid_o = nonempty_r;
  assign out_data_o  = mem[rd_ptr_r];
endmodule : ebi_fifo

// file: design/ebi_mem_ctrl_end.sv
// Memory controller end: acknowledges transfers, read data from a FIFO
`timescale 1ns/10ps
module ebi_mem_ctrl_end #(
  parameter int READ_WAITS  = 2,
  parameter int BURST_WAITS = 0,
  parameter int WRITE_WAITS = 2,
  parameter int FIFO_WORDS  = ebi_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // Read data source
  input  wire logic                        src_valid_i,
  output logic                             src_ready_o,
  input  wire logic [ebi_pkg::DATA_W-1:0]  src_data_i,
  // Error injection for reads
  input  wire logic                        fault_request_i,
  // Write sink
  output logic                             wr_valid_o,
  output logic [ebi_pkg::ADDR_W-1:0]       wr_addr_o,
  output logic [ebi_pkg::BE_W-1:0]         wr_byte_en_n_o,
  output logic [ebi_pkg::DATA_W-1:0]       wr_data_o,
  // Bus
  ebi_bus_if.ctl                           bus
);
  import ebi_pkg::*;

  if (READ_WAITS >= (1 << WAIT_W) || BURST_WAITS >= (1 << WAIT_W) ||
      WRITE_WAITS >= (1 << WAIT_W) || READ_WAITS < 0 ||
      BURST_WAITS < 0 || WRITE_WAITS < 0) begin : g_bad
    $error("ebi_mem_ctrl_end: wait counts must fit the wait counter");
  end

  logic              busy_r;
  logic              wr_r;
  logic [CNT_W-1:0]  left_r;
  logic [WAIT_W-1:0] wait_r;
  logic              ack_n_r;
  logic              fault_n_r;
  logic              oe_r;
  logic [DATA_W-1:0] pend_r;
  logic [DATA_W-1:0] dat_r;
  logic              wr_valid_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [BE_W-1:0]   wr_be_r;
  logic [DATA_W-1:0] wr_data_r;
  logic              q_valid;
  logic [DATA_W-1:0] q_data;

  wire tick     = bus.bus_tick;
  // Device samples the acknowledge at this bus edge
  wire sampled  = tick & busy_r & ~ack_n_r;
  wire more     = sampled ? (left_r != ONE_WORD) & ~wr_r : busy_r;
  wire [WAIT_W-1:0] wait_now = sampled ? WAIT_W'(BURST_WAITS) : wait_r;
  wire fault_go = tick & busy_r & ~wr_r & ack_n_r & fault_request_i;
  // Acknowledge reads only with FIFO data in hand (writes need none); an empty FIFO adds waits
  wire ack_go   = tick & busy_r & ~fault_go & more & (wait_now == '0) &
                  (wr_r | q_valid);
  wire pop      = ack_go & ~wr_r;
  wire start    = tick & ~busy_r & ~bus.bus_cycle_begin_n;

  ebi_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_WORDS)) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (src_valid_i),
    .in_ready_o  (src_ready_o),
    .in_data_i   (src_data_i),
    .out_valid_o (q_valid),
    .out_ready_i (pop),
    .out_data_o  (q_data)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      busy_r     <= 1'b0;
      wr_r       <= 1'b0;
      left_r     <= '0;
      wait_r     <= '0;
      ack_n_r    <= 1'b1;
      fault_n_r  <= 1'b1;
      oe_r       <= 1'b0;
      wr_valid_r <= 1'b0;
    end else begin
      wr_valid_r <= sampled & wr_r;
      if (tick) begin
        ack_n_r   <= ~ack_go;
        fault_n_r <= ~fault_go;
        oe_r      <= sampled & ~wr_r;
      end
      if (start) begin
        busy_r <= 1'b1;
        wr_r   <= ~bus.store_strobe_n;
        left_r <= bus.multiword_read_n ? ONE_WORD :
                  CNT_W'(BURST_BASE_WORDS << bus.burst_length_code);
        wait_r <= ~bus.store_strobe_n ? WAIT_W'(WRITE_WAITS) :
                  WAIT_W'(READ_WAITS);
      end else if (fault_go) begin
        busy_r <= 1'b0;
      end else if (sampled) begin
        left_r <= left_r - ONE_WORD;
        wait_r <= WAIT_W'(BURST_WAITS);
        if (!more) busy_r <= 1'b0;
      end else if (tick && busy_r && wait_r != '0) begin
        wait_r <= wait_r - 1'b1;
      end
    end
  end

  // Data lags its acknowledge by one bus clock, so the device captures it
  always_ff @(posedge clk_i) begin
    if (pop) pend_r <= q_data;
    if (sampled) dat_r <= pend_r;
    if (sampled & wr_r) begin
      wr_addr_r <= bus.word_addr;
      wr_be_r   <= bus.byte_lane_enable_n;
      wr_data_r <= bus.data;
    end
  end

  assign bus.target_done_n  = ack_n_r;
  assign bus.bus_fault_in_n = fault_n_r;
  assign bus.ctl_data_oe    = oe_r;
  assign bus.ctl_data       = dat_r;
  assign wr_valid_o         = wr_valid_r;
  assign wr_addr_o          = wr_addr_r;
  assign wr_byte_en_n_o     = wr_be_r;
  assign wr_data_o          = wr_data_r;
endmodule : ebi_mem_ctrl_end

// file: sim/ebi_chk_sva.sv
// Protocol checks on the bus joining the two ends
`timescale 1ns/10ps
module ebi_chk (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   reset_n_i,
  // Bus pins
  input wire logic                   bus_tick,
  input wire logic                   bus_cycle_begin_n,
  input wire logic                   read_strobe_n,
  input wire logic                   store_strobe_n,
  input wire logic                   final_transfer_n,
  input wire logic                   multiword_read_n,
  input wire logic [ebi_pkg::BE_W-1:0]   byte_lane_enable_n,
  input wire logic [ebi_pkg::ADDR_W-1:0] word_addr,
  input wire logic                   dev_data_oe,
  input wire logic                   target_done_n,
  input wire logic                   bus_fault_in_n
);
  import ebi_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire rd_x = !read_strobe_n;
  wire st_x = !store_strobe_n;
  property p_begin_strobe; !bus_cycle_begin_n |-> rd_x || st_x; endproperty
  a_begin_strobe: assert property (p_begin_strobe) else $error("begin");
  property p_begin_one; bus_tick && !bus_cycle_begin_n |=> bus_cycle_begin_n;
  endproperty
  a_begin_one: assert property (p_begin_one) else $error("begin len");
  property p_idle; !rd_x && !st_x |-> !dev_data_oe && bus_cycle_begin_n &&
    final_transfer_n && multiword_read_n && byte_lane_enable_n == BE_IDLE_N;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pins");
  property p_wr_first; st_x && !bus_cycle_begin_n |-> !dev_data_oe;
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("wr data");
  property p_multi; !multiword_read_n |-> rd_x; endproperty
  a_multi: assert property (p_multi) else $error("multiword");
  property p_ack_final; bus_tick && !target_done_n && !final_transfer_n &&
    multiword_read_n |=> final_transfer_n; endproperty
  a_ack_final: assert property (p_ack_final) else $error("final");
  property p_wait_hold; bus_tick && target_done_n && bus_fault_in_n &&
    !final_transfer_n && multiword_read_n |=> $stable(word_addr) &&
    $stable(read_strobe_n) && $stable(store_strobe_n) &&
    $stable(byte_lane_enable_n); endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait");
  property p_fault_end; bus_tick && !bus_fault_in_n && rd_x |=> !rd_x;
  endproperty
  a_fault_end: assert property (p_fault_end) else $error("fault");
  c_burst: cover property (!multiword_read_n && !target_done_n);
  c_write: cover property (st_x && dev_data_oe && !target_done_n);
  c_fault: cover property (rd_x && !bus_fault_in_n);
endmodule : ebi_chk

// file: sim/tb.sv
// Self-checking bench joining both ends of the external bus
`timescale 1ns/10ps
module tb;
  import ebi_pkg::*;
  logic clk = 0, rst_n = 0, rv = 0, w = 0, c = 0, ins = 0, sv = 0, fr = 0;
  logic nmi = 1, own = 0, half = 1, dmw = 0, ice = 1, dce = 1;
  logic [1:0] div = 0, il = 0, dl = 0;
  logic [29:0] a = 0, wa;
  logic [31:0] d = 0, sd = 0, rdat, wdat;
  logic [5:0] irq_n = 6'h3F, msk = 0, pend;
  logic [3:0] wbe;
  logic rdy, rvl, rl, be, wd, nx, ie, srdy, wv, fc;
  int failures = 0, num_checks = 0, cyc = 0, nrd = 0, nerr = 0, nnmi = 0, k;
  int nwr = 0, nwd = 0;
  logic [31:0] expq[$];
  ebi_bus_if bus();
  ebi_cpu_end i_ebi_cpu_end (.clk_i(clk), .reset_n_i(rst_n),
    .clock_divide_select_i(div), .bus_halving_select_i(half),
    .free_running_clock_o(fc), .req_valid_i(rv), .req_ready_o(rdy),
    .req_write_i(w), .req_cached_i(c), .req_instr_i(ins), .req_addr_i(a),
    .req_byte_en_n_i(~a[3:0]), .req_wdata_i(d), .icache_enable_i(ice),
    .dcache_enable_i(dce), .dcache_multiword_refill_i(dmw),
    .icache_refill_length_i(il), .dcache_refill_length_i(dl),
    .rd_valid_o(rvl), .rd_data_o(rdat), .rd_last_o(rl), .bus_error_o(be),
    .write_done_o(wd), .nmi_n_i(nmi), .int_n_i(irq_n),
    .irq_mask_field_i(msk), .other_master_owns_i(own),
    .nmi_exception_o(nx), .pending_irq_field_o(pend),
    .irq_exception_o(ie), .bus(bus.dev));
  ebi_mem_ctrl_end i_ebi_mem_ctrl_end (.clk_i(clk), .reset_n_i(rst_n),
    .src_valid_i(sv), .src_ready_o(srdy), .src_data_i(sd),
    .fault_request_i(fr), .wr_valid_o(wv), .wr_addr_o(wa),
    .wr_byte_en_n_o(wbe), .wr_data_o(wdat), .bus(bus.ctl));
  ebi_chk i_ebi_chk (.clk_i(clk), .reset_n_i(rst_n), .bus_tick(bus.bus_tick),
    .bus_cycle_begin_n(bus.bus_cycle_begin_n),
    .read_strobe_n(bus.read_strobe_n), .store_strobe_n(bus.store_strobe_n),
    .final_transfer_n(bus.final_transfer_n),
    .multiword_read_n(bus.multiword_read_n),
    .byte_lane_enable_n(bus.byte_lane_enable_n), .word_addr(bus.word_addr),
    .dev_data_oe(bus.dev_data_oe), .target_done_n(bus.target_done_n),
    .bus_fault_in_n(bus.bus_fault_in_n));
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Hold valid until the edge that sees ready, then release
  task push(input logic [31:0] v);
    @(negedge clk); sv = 1; sd = v; expq.push_back(v);
    for (k = 0; !srdy && k < 99; k++) @(negedge clk);
    @(negedge clk); sv = 0;
  endtask : push
  task go(input logic wr, cc, ii, input logic [29:0] ad,
          input logic [31:0] dd);
    @(negedge clk); rv = 1; w = wr; c = cc; ins = ii; a = ad; d = dd;
    for (k = 0; !rdy && k < 99; k++) @(negedge clk);
    @(negedge clk); rv = 0;
    for (k = 0; !rdy && k < 300; k++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask : go
  always @(posedge clk) begin
    cyc++;
    if (rst_n && rvl === 1'h1) begin
      chk(rl, expq.size() == 1);
      chk(rdat, expq.pop_front());
      nrd++;
    end
    if (rst_n && wv === 1'h1) begin
      chk(wdat, d);
      chk({wbe, wa[27:0]}, {~a[3:0], a[27:0]});
    end
    nerr += (be === 1'h1); nnmi += (nx === 1'h1); nwr += (wv === 1'h1);
    nwd += (wd === 1'h1);
    // Timeout is the last act of this process
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(negedge clk); rst_n = 1;
    @(negedge clk);
    k = fc;
    @(negedge clk);
    chk(fc, !k[0]);
    for (int n = 0; n < 8; n++) begin
      @(negedge clk); div = n[1:0]; half = n[2];
      repeat (3) @(posedge clk iff bus.bus_tick === 1'h1);
      k = 0;
      do begin @(posedge clk); k++; end while (bus.bus_tick !== 1'h1);
      chk(k, (2 - n[2]) << n[1:0]);
    end
    @(negedge clk); div = 0; half = 1;
    push(32'h1234ABCD); go(0, 1, 0, 30'h10, 0); chk(nrd, 1);
    go(1, 0, 0, 30'h2A5, 32'hA5C30F96); chk(nwr, 1);
    chk(nwd, 1);
    dmw = 1; il = 1;
    for (int j = 0; j < 2; j++) begin
      for (int n = 0; n < (4 << j); n++) push(32'hB00 + n);
      go(0, 1, j[0], 30'h40, 0);
    end
    chk(nrd, 13);
    fr = 1; go(0, 0, 0, 30'h8, 0); go(0, 1, 0, 30'h80, 0); fr = 0;
    chk(nerr, 2); chk(nrd, 13);
    // Cached misses with a cache disabled must fall back to single reads
    ice = 0;
    push(32'hC0DE0001);
    go(0, 1, 1, 30'h20, 0);
    ice = 1;
    dce = 0;
    push(32'hC0DE0002);
    go(0, 1, 0, 30'h24, 0);
    chk(nrd, 15);
    dce = 1;
    own = 1; nmi = 0; repeat (20) @(negedge clk); chk(nnmi, 0);
    own = 0; repeat (20) @(negedge clk); chk(nnmi, 1); nmi = 1;
    irq_n = 6'h3E; msk = 6'h01; repeat (12) @(negedge clk);
    chk({ie, pend}, 7'h41); msk = 6'h02; repeat (6) @(negedge clk);
    chk(ie, 0);
    tally_and_finish;
  end
endmodule : tb
